// File: rtl/rscc_ctrl.sv
// reset source controller: merges reset sources, runs the boot sequence,
// keeps the cause flags and brown-out settings in one register
// assumes supply monitors and the pin are asynchronous; watchdog and debug
// requests and the register port are on mclk
//
// Overview of operation
// - any reset presents pc 0000h, acc 00h, sp 07h, clock on, brown-out on
// - pin, power-on, watchdog, brown-out and debug all drive system reset
// - watchdog overflow resets only while the watchdog enable setting is 1
// - brown-out detection resets only while the brown-out enable bit is 1
// - pin lows shorter than about 7us are filtered out
// - after the pin returns high, wait 16ms before releasing reset
// - reset processing takes 5 oscillator clocks after the wait
// - execution starts at the vector held at address 0000h
// - on power-on start 125kHz oscillator, wait 30h x 32 periods
// - at end of power-up delay read and apply configuration
// - release is marked by a 16ms interval timer overflow
// - with power-on reset only, the reset pin may serve as plain i/o
// - two-bit level field selects 1.6V, 2.5V, 3.6V or 4.2V trip
// - brown-out enable bit turns detection on or off; software may clear
// - register holds power-on, pin, watchdog, debug, brown-out flags, level, enable
// - power-on flag sets on power-on, cleared only by writing 0
// - other flags set by their reset, cleared by writing 0 or power-on
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
module rscc_ctrl
   import rscc_pkg::*;
#(
   parameter int OSC_DIV = rscc_pkg::RSCC_OSC_DIV,
   parameter int FILT_CYC = rscc_pkg::RSCC_FILT_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // reset sources
   input wire logic external_reset_pin_n,
   input wire logic power_on_detect,
   input wire logic brownout_detect,
   input wire logic watchdog_overflow,
   input wire logic watchdog_enable_setting,
   input wire logic debug_reset_req,
   // configuration storage
   input wire logic [7:0] cfg_data,
   output logic cfg_read_r,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_r,
   // to the core and analog blocks
   output logic system_reset_r,
   output logic osc_enable_r,
   output logic pin_is_gpio_r,
   output logic brownout_enable_r,
   output logic [1:0] brownout_level_select_r,
   output logic periph_clk_on_r,
   output logic [15:0] pc_init_r,
   output logic [7:0] acc_init_r,
   output logic [7:0] sp_init_r,
   output logic [15:0] vector_addr_r
);
   import rscc_pkg::*;

   typedef struct packed {
      rscc_state_e st;
      logic [15:0] div_cnt;
      logic tick;
      logic [10:0] cnt;
      logic [4:0] flags;
      logic [1:0] lvl;
      logic en;
      logic [7:0] rdata;
      logic rst_out;
      logic cfg_rd;
      logic [7:0] cfg_word;
      logic osc_en;
      logic pin_s1;
      logic pin_s2;
      logic por_s1;
      logic por_s2;
      logic brown_s1;
      logic brown_s2;
   } rscc_regs_s;

   localparam rscc_regs_s RST_VAL = '{
      st: RSCC_ST_OFF, div_cnt: '0, tick: 1'b0, cnt: '0,
      flags: RSCC_FLAGS_POR, lvl: RSCC_LVL_RST, en: 1'b1, rdata: RSCC_RD_IDLE,
      rst_out: 1'b1, cfg_rd: 1'b0, cfg_word: '0, osc_en: 1'b0,
      pin_s1: 1'b1, pin_s2: 1'b1, por_s1: 1'b1, por_s2: 1'b1,
      brown_s1: 1'b0, brown_s2: 1'b0};

   rscc_regs_s state_r, state_nxt;
   logic pin_low;
   logic pin_ev, wdog_ev, brown_ev, dbg_ev, any_ev;

   generate
      if (OSC_DIV < 2 || OSC_DIV > 65535) begin : g_bad
         $error("rscc_ctrl: OSC_DIV out of range");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // pin noise canceller, fed from the synchronised pin

   rscc_low_filter #(
      .LOW_CYC(FILT_CYC)
   ) u_pin_filter (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .level_in(state_r.pin_s2),
      .low_seen_r(pin_low)
   );

   ////////////////////////////////////////////////////////////////////////////
   // reset source qualification

   always_comb begin
      pin_ev = pin_low && !state_r.cfg_word[RSCC_CFG_PIN_GPIO];
      wdog_ev = watchdog_overflow && watchdog_enable_setting;
      brown_ev = state_r.brown_s2 && state_r.en;
      dbg_ev = debug_reset_req;
      any_ev = pin_ev || wdog_ev || brown_ev || dbg_ev;
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      state_nxt = state_r;
      state_nxt.pin_s1 = external_reset_pin_n;
      state_nxt.pin_s2 = state_r.pin_s1;
      state_nxt.por_s1 = power_on_detect;
      state_nxt.por_s2 = state_r.por_s1;
      state_nxt.brown_s1 = brownout_detect;
      state_nxt.brown_s2 = state_r.brown_s1;
      state_nxt.cfg_rd = 1'b0;

      // 125 kHz oscillator period derived from mclk
      state_nxt.tick = 1'b0;
      if (!state_r.osc_en) begin
         state_nxt.div_cnt = '0;
      end else if (state_r.div_cnt == 16'(OSC_DIV - 1)) begin
         state_nxt.div_cnt = '0;
         state_nxt.tick = 1'b1;
      end else begin
         state_nxt.div_cnt = state_r.div_cnt + 16'd1;
      end

      // read data stand only in the cycle after the strobe
      state_nxt.rdata = RSCC_RD_IDLE;
      if (reg_rd && reg_addr == RSCC_CAUSE_ADDR) begin
         state_nxt.rdata = {state_r.flags, state_r.lvl, state_r.en};
      end

      // writing 0 clears a flag, writing 1 leaves it
      if (reg_wr && reg_addr == RSCC_CAUSE_ADDR) begin
         state_nxt.flags = state_r.flags & reg_wdata[RSCC_BIT_POR:RSCC_BIT_BROWN];
         state_nxt.lvl = reg_wdata[RSCC_LVL_HI:RSCC_LVL_LO];
         state_nxt.en = reg_wdata[RSCC_BIT_EN];
      end

      // a source firing in the same cycle as a clearing write wins
      state_nxt.flags[RSCC_F_PIN] = state_nxt.flags[RSCC_F_PIN] | pin_ev;
      state_nxt.flags[RSCC_F_WDOG] = state_nxt.flags[RSCC_F_WDOG] | wdog_ev;
      state_nxt.flags[RSCC_F_DBG] = state_nxt.flags[RSCC_F_DBG] | dbg_ev;
      state_nxt.flags[RSCC_F_BROWN] = state_nxt.flags[RSCC_F_BROWN] | brown_ev;

      unique case (state_r.st)
         RSCC_ST_OFF: begin
            state_nxt.cnt = '0;
            if (!state_r.por_s2) begin
               state_nxt.st = RSCC_ST_DELAY;
               state_nxt.osc_en = 1'b1;
            end
         end
         RSCC_ST_DELAY: begin
            if (state_r.tick) begin
               if (state_r.cnt == RSCC_PWRUP_TICKS - 11'd1) begin
                  state_nxt.st = RSCC_ST_CFG;
                  state_nxt.cfg_rd = 1'b1;
                  state_nxt.cnt = '0;
               end else begin
                  state_nxt.cnt = state_r.cnt + 11'd1;
               end
            end
         end
         RSCC_ST_CFG: begin
            state_nxt.cfg_word = cfg_data;
            state_nxt.st = RSCC_ST_STAB;
            state_nxt.cnt = '0;
         end
         RSCC_ST_STAB: begin
            if (state_r.tick) begin
               if (state_r.cnt == RSCC_STAB_TICKS - 11'd1) begin
                  state_nxt.st = RSCC_ST_PROC;
                  state_nxt.cnt = '0;
               end else begin
                  state_nxt.cnt = state_r.cnt + 11'd1;
               end
            end
         end
         RSCC_ST_PROC: begin
            if (state_r.tick) begin
               if (state_r.cnt == RSCC_PROC_TICKS - 11'd1) begin
                  state_nxt.st = RSCC_ST_RUN;
                  state_nxt.rst_out = 1'b0;
               end else begin
                  state_nxt.cnt = state_r.cnt + 11'd1;
               end
            end
         end
         RSCC_ST_RUN: begin
            state_nxt.cnt = '0;
         end
         RSCC_ST_HOLD: begin
            state_nxt.cnt = '0;
            if (!any_ev) begin
               state_nxt.st = RSCC_ST_STAB;
            end
         end
         default: begin
            state_nxt.st = RSCC_ST_OFF;
         end
      endcase

      // sources are honoured once the power-up delay has ended; the flags
      // stay as recorded so software can read the cause after restart
      if (any_ev && state_r.st != RSCC_ST_OFF && state_r.st != RSCC_ST_DELAY) begin
         state_nxt.st = RSCC_ST_HOLD;
         state_nxt.rst_out = 1'b1;
         state_nxt.cnt = '0;
         state_nxt.en = 1'b1;
         state_nxt.lvl = RSCC_LVL_RST;
      end

      // power-on wins over everything and restarts the whole boot
      if (state_r.por_s2) begin
         state_nxt.st = RSCC_ST_OFF;
         state_nxt.rst_out = 1'b1;
         state_nxt.osc_en = 1'b0;
         state_nxt.cnt = '0;
         state_nxt.flags = RSCC_FLAGS_POR;
         state_nxt.lvl = RSCC_LVL_RST;
         state_nxt.en = 1'b1;
         state_nxt.cfg_word = '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_r <= RST_VAL;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign system_reset_r = state_r.rst_out;
   assign osc_enable_r = state_r.osc_en;
   assign cfg_read_r = state_r.cfg_rd;
   assign reg_rdata_r = state_r.rdata;
   assign pin_is_gpio_r = state_r.cfg_word[RSCC_CFG_PIN_GPIO];
   assign brownout_enable_r = state_r.en;
   assign brownout_level_select_r = state_r.lvl;
   // core load values are fixed; the core takes them while reset stands
   assign periph_clk_on_r = 1'b1;
   assign pc_init_r = RSCC_PC_INIT;
   assign acc_init_r = RSCC_ACC_INIT;
   assign sp_init_r = RSCC_SP_INIT;
   assign vector_addr_r = RSCC_VECTOR_ADDR;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_wdog_gated: assert property ($rose(state_r.flags[RSCC_F_WDOG]) |->
      $past(watchdog_overflow && watchdog_enable_setting))
      else $error("watchdog flag set without enabled overflow");

   a_brown_gated: assert property ($rose(state_r.flags[RSCC_F_BROWN]) |->
      $past(state_r.brown_s2 && state_r.en))
      else $error("brown-out flag set while detection disabled");

   a_pin_filter: assert property ($rose(pin_low) |->
      $past(!state_r.pin_s2) && $past(!state_r.pin_s2, 8))
      else $error("short pin low passed the filter");

   a_release_path: assert property ($fell(state_r.rst_out) |->
      $past(state_r.st) == RSCC_ST_PROC && $past(state_r.tick))
      else $error("reset released outside the processing step");

   a_proc_len: assert property ($past(state_r.st) == RSCC_ST_PROC &&
      state_r.st == RSCC_ST_RUN |-> $past(state_r.cnt) == RSCC_PROC_TICKS - 11'd1)
      else $error("processing step length wrong");

   a_cfg_apply: assert property (state_r.cfg_rd && !state_r.por_s2 && !any_ev
      |=> state_r.st == RSCC_ST_STAB && state_r.cfg_word == $past(cfg_data))
      else $error("configuration not applied");

   a_por_flags: assert property (state_r.por_s2 |=>
      state_r.flags == RSCC_FLAGS_POR && state_r.en && state_r.rst_out)
      else $error("power-on did not set cause register");

   a_flags_kept: assert property (!$past(reg_wr) && !$past(state_r.por_s2) |->
      (state_r.flags & $past(state_r.flags)) == $past(state_r.flags))
      else $error("cause flag lost without a write");

   a_read_data: assert property (reg_rd && reg_addr == RSCC_CAUSE_ADDR |=>
      reg_rdata_r == $past({state_r.flags, state_r.lvl, state_r.en}))
      else $error("register read data wrong");

   a_reset_enables: assert property ($rose(state_r.rst_out) |-> state_r.en)
      else $error("brown-out not enabled at reset");

   a_rdata_idle: assert property (!(reg_rd && reg_addr == RSCC_CAUSE_ADDR) |=>
      reg_rdata_r == RSCC_RD_IDLE)
      else $error("read data not idle outside a read");

   a_pin_gated: assert property ($rose(state_r.flags[RSCC_F_PIN]) |->
      $past(pin_low && !state_r.cfg_word[RSCC_CFG_PIN_GPIO]))
      else $error("pin flag set while the pin serves as i/o");

   a_hold_reset: assert property (state_r.st == RSCC_ST_HOLD |-> state_r.rst_out)
      else $error("system reset low while a source holds it");

   a_dbg_flag: assert property ($rose(state_r.flags[RSCC_F_DBG]) |->
      $past(debug_reset_req))
      else $error("debug flag set without a request");

   c_boot_done: cover property ($fell(state_r.rst_out));
   c_wdog_reset: cover property (wdog_ev && state_r.st == RSCC_ST_RUN);
   c_pin_reset: cover property (pin_ev && state_r.st == RSCC_ST_RUN);
   c_brown_reset: cover property (brown_ev && state_r.st == RSCC_ST_RUN);
   c_dbg_reset: cover property (dbg_ev && state_r.st == RSCC_ST_RUN);

endmodule

// File: rtl/rscc_pkg.sv
// reset source controller: shared constants, register layout and state codes
// assumes a single 200 MHz system clock with a synchronous active-high reset
package rscc_pkg;

   // register map
   localparam logic [7:0] RSCC_CAUSE_ADDR = 8'h86;
   localparam logic [7:0] RSCC_CAUSE_RST = 8'h81;
   localparam logic [7:0] RSCC_RD_IDLE = 8'h00;

   // field positions inside the cause register
   localparam int RSCC_BIT_POR = 7;
   localparam int RSCC_BIT_PIN = 6;
   localparam int RSCC_BIT_WDOG = 5;
   localparam int RSCC_BIT_DBG = 4;
   localparam int RSCC_BIT_BROWN = 3;
   localparam int RSCC_LVL_HI = 2;
   localparam int RSCC_LVL_LO = 1;
   localparam int RSCC_BIT_EN = 0;
   // flag vector index: {por, pin, wdog, dbg, brown}
   localparam int RSCC_F_POR = 4;
   localparam int RSCC_F_PIN = 3;
   localparam int RSCC_F_WDOG = 2;
   localparam int RSCC_F_DBG = 1;
   localparam int RSCC_F_BROWN = 0;
   localparam logic [4:0] RSCC_FLAGS_POR = 5'h10;
   localparam logic [1:0] RSCC_LVL_RST = 2'h0;

   // values the core takes on any reset
   localparam logic [15:0] RSCC_PC_INIT = 16'h0000;
   localparam logic [7:0] RSCC_ACC_INIT = 8'h00;
   localparam logic [7:0] RSCC_SP_INIT = 8'h07;
   localparam logic [15:0] RSCC_VECTOR_ADDR = 16'h0000;

   // configuration option bit that turns the reset pin into plain i/o
   localparam int RSCC_CFG_PIN_GPIO = 0;

   // timing
   localparam int RSCC_MCLK_HZ = 200_000_000;
   localparam int RSCC_MCLK_NS = 5;
   localparam int RSCC_OSC_HZ = 125_000;
   localparam int RSCC_OSC_NS = 8000;
   localparam int RSCC_OSC_DIV = RSCC_MCLK_HZ / RSCC_OSC_HZ;
   localparam int RSCC_FILT_NS = 7000;
   localparam int RSCC_FILT_CYC = (RSCC_FILT_NS + RSCC_MCLK_NS - 1) / RSCC_MCLK_NS;
   localparam int RSCC_STAB_NS = 16_000_000;
   localparam logic [10:0] RSCC_STAB_TICKS =
      11'((RSCC_STAB_NS + RSCC_OSC_NS - 1) / RSCC_OSC_NS);
   localparam int RSCC_PWRUP_UNITS = 'h30;
   localparam int RSCC_PWRUP_PRESC = 32;
   localparam logic [10:0] RSCC_PWRUP_TICKS = 11'(RSCC_PWRUP_UNITS * RSCC_PWRUP_PRESC);
   localparam logic [10:0] RSCC_PROC_TICKS = 11'd5;

   typedef enum logic [2:0] {
      RSCC_ST_OFF = 3'b000,
      RSCC_ST_DELAY = 3'b001,
      RSCC_ST_CFG = 3'b011,
      RSCC_ST_STAB = 3'b010,
      RSCC_ST_PROC = 3'b110,
      RSCC_ST_RUN = 3'b111,
      RSCC_ST_HOLD = 3'b101
   } rscc_state_e;

endpackage

// File: rtl/rscc_low_filter.sv
// reset source controller: low-level noise canceller for the reset pin
// assumes its input is already synchronised to mclk
`timescale 1ns/100ps
module rscc_low_filter #(
   parameter int LOW_CYC = 1400
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // level in, filtered low indication out
   input wire logic level_in,
   output logic low_seen_r
);
   localparam int CW = $clog2(LOW_CYC + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic low;
   } rscc_filt_s;

   rscc_filt_s state_r, state_nxt;

   generate
      if (LOW_CYC < 1) begin : g_bad
         $error("rscc_low_filter: LOW_CYC must be at least 1");
      end
   endgenerate

   // a glitch restarts the count, so only a sustained low gets through
   always_comb begin
      state_nxt = state_r;
      if (level_in) begin
         state_nxt.cnt = '0;
         state_nxt.low = 1'b0;
      end else if (state_r.cnt == CW'(LOW_CYC - 1)) begin
         state_nxt.low = 1'b1;
      end else begin
         state_nxt.cnt = state_r.cnt + CW'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign low_seen_r = state_r.low;

endmodule

// File: dv/rscc_src_model.sv
// reset source controller bench: pin driver, supply monitors, watchdog,
// debug unit and configuration storage seen from outside the block
// assumes the bench calls its tasks from a single process
`timescale 1ns/100ps
module rscc_src_model (
   // clock
   input wire logic mclk,
   // configuration storage
   input wire logic cfg_read_r,
   output logic [7:0] cfg_data,
   // reset sources
   output logic external_reset_pin_n,
   output logic power_on_detect,
   output logic brownout_detect,
   output logic watchdog_overflow,
   output logic debug_reset_req
);
   logic [7:0] cfg_val = 8'h00;

   // storage answers only inside the read strobe; the inverse elsewhere
   // catches a design that samples the byte a cycle early or late
   assign cfg_data = cfg_read_r ? cfg_val : ~cfg_val;

   initial begin
      external_reset_pin_n = 1'b1;
      power_on_detect = 1'b1;
      brownout_detect = 1'b0;
      watchdog_overflow = 1'b0;
      debug_reset_req = 1'b0;
   end

   // source 0 pin, 1 power-on, 2 brown-out, 3 watchdog, 4 debug
   task automatic set(input int src, input logic on);
      @(posedge mclk);
      case (src)
         0: external_reset_pin_n <= ~on;
         1: power_on_detect <= on;
         2: brownout_detect <= on;
         3: watchdog_overflow <= on;
         default: debug_reset_req <= on;
      endcase
   endtask

   // asserts a source for n cycles; a pin reset needs n of at least the filter
   task automatic hold(input int src, input int n);
      set(src, 1'b1);
      repeat (n - 1) @(posedge mclk);
      set(src, 1'b0);
      #1;
   endtask
endmodule

// File: dv/rscc_ctrl_tb.sv
// reset source controller bench: boot sequence, sources, cause register
// assumes the design runs with a short oscillator divider and filter
`timescale 1ns/100ps
module rscc_ctrl_tb;
   import rscc_pkg::*;
   localparam int DIV = 4;
   localparam int FILT = 10;
   localparam int T_CFG = int'(RSCC_PWRUP_TICKS) * DIV;
   localparam int T_REL = (int'(RSCC_STAB_TICKS) + int'(RSCC_PROC_TICKS)) * DIV;
   localparam int LIMIT = 90000;
   logic mclk, sys_rst, pin_n, por, brown, wdog, wdog_en, dbg, cfg_rd, reg_wr, reg_rd;
   logic [7:0] cfg_data, reg_addr, reg_wdata, reg_rdata_r, acc, sp;
   logic system_reset_r, osc_enable_r, pin_is_gpio_r, brown_en, periph;
   logic [1:0] lvl_r;
   logic [15:0] pc, vec;
   int failures = 0;
   int checks = 0;
   int cycles = 0;

   rscc_ctrl #(.OSC_DIV(DIV), .FILT_CYC(FILT)) i_rscc_ctrl (.mclk(mclk), .sys_rst(sys_rst),
      .external_reset_pin_n(pin_n), .power_on_detect(por), .brownout_detect(brown),
      .watchdog_overflow(wdog), .watchdog_enable_setting(wdog_en), .debug_reset_req(dbg),
      .cfg_data(cfg_data), .cfg_read_r(cfg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
      .system_reset_r(system_reset_r), .osc_enable_r(osc_enable_r),
      .pin_is_gpio_r(pin_is_gpio_r), .brownout_enable_r(brown_en),
      .brownout_level_select_r(lvl_r), .periph_clk_on_r(periph), .pc_init_r(pc),
      .acc_init_r(acc), .sp_init_r(sp), .vector_addr_r(vec));
   rscc_src_model i_rscc_src_model (.mclk(mclk), .cfg_read_r(cfg_rd), .cfg_data(cfg_data),
      .external_reset_pin_n(pin_n), .power_on_detect(por), .brownout_detect(brown),
      .watchdog_overflow(wdog), .debug_reset_req(dbg));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         close_out();
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [15:0] in_win(input int n, input int t);
      return {15'h0, n >= t - DIV - 2 && n <= t + DIV + 8};
   endfunction

   function automatic logic sig(input int sel);
      case (sel)
         0: return system_reset_r;
         1: return osc_enable_r;
         default: return cfg_rd;
      endcase
   endfunction

   // bounded wait for a level; called just after an edge
   task automatic wait_for(input int sel, input logic lvl, input int bound, output int n);
      n = 0;
      while (sig(sel) !== lvl && n < bound) begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      check(what, {8'h00, reg_rdata_r}, {8'h00, exp});
      @(posedge mclk);
      #1;
      check("read idle", {8'h00, reg_rdata_r}, {8'h00, RSCC_RD_IDLE});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic boot(input logic [7:0] cfg);
      int n;
      i_rscc_src_model.cfg_val = cfg;
      i_rscc_src_model.set(1, 1'b0);
      wait_for(1, 1'b1, 20, n);
      check("osc start", {15'h0, osc_enable_r}, 16'h1);
      wait_for(2, 1'b1, T_CFG + 50, n);
      check("power-up delay", in_win(n, T_CFG), 16'h1);
      @(posedge mclk);
      #1;
      check("cfg applied", {15'h0, pin_is_gpio_r}, {15'h0, cfg[0]});
      check("held to release", {15'h0, system_reset_r}, 16'h1);
      wait_for(0, 1'b0, T_REL + 50, n);
      check("boot release", in_win(n, T_REL), 16'h1);
   endtask

   task automatic src_reset(input int src, input int len, input logic [7:0] exp);
      int n;
      i_rscc_src_model.hold(src, len);
      wait_for(0, 1'b1, 6, n);
      check("reset raised", {15'h0, system_reset_r}, 16'h1);
      wait_for(0, 1'b0, T_REL + 50, n);
      check("source release", in_win(n, T_REL), 16'h1);
      rd("cause", RSCC_CAUSE_ADDR, exp);
   endtask

   task automatic no_reset(input int src, input int len);
      int n;
      i_rscc_src_model.hold(src, len);
      wait_for(0, 1'b1, 8, n);
      check("no reset", {15'h0, system_reset_r}, 16'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic init_values;
      check("pc", pc, 16'h0000);
      check("acc", {8'h00, acc}, 16'h0000);
      check("sp", {8'h00, sp}, 16'h0007);
      check("periph clk", {15'h0, periph}, 16'h1);
      check("vector", vec, 16'h0000);
      rd("cause at reset", RSCC_CAUSE_ADDR, 8'h81);
   endtask

   task automatic cause_reg;
      // ones to flags leave them alone; enable cleared by software
      wr(RSCC_CAUSE_ADDR, 8'hfe);
      rd("ones to flags", RSCC_CAUSE_ADDR, 8'h86);
      check("brown-out enable off", {15'h0, brown_en}, 16'h0);
      for (int l = 0; l < 4; l++) begin
         wr(RSCC_CAUSE_ADDR, {5'h00, 2'(l), 1'b1});
         rd("level", RSCC_CAUSE_ADDR, {5'h00, 2'(l), 1'b1});
         check("level out", {14'h0, lvl_r}, 16'(l));
      end
      wr(8'h87, 8'h00);
      rd("unmapped", 8'h87, 8'h00);
      rd("unmapped kept", RSCC_CAUSE_ADDR, 8'h07);
   endtask

   task automatic por_restart;
      i_rscc_src_model.set(1, 1'b1);
      repeat (4) @(posedge mclk);
      rd("power-on clears", RSCC_CAUSE_ADDR, 8'h81);
      check("power-on held", {15'h0, system_reset_r}, 16'h1);
      boot(8'h01);
      no_reset(0, FILT + 8);
      rd("pin as i/o", RSCC_CAUSE_ADDR, 8'h81);
   endtask

   initial begin
      sys_rst = 1'b1;
      wdog_en = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      #1;
      init_values();
      boot(8'h00);
      cause_reg();
      no_reset(0, FILT - 3);
      src_reset(0, FILT + 8, 8'h41);
      wr(RSCC_CAUSE_ADDR, 8'h00);
      rd("flags cleared", RSCC_CAUSE_ADDR, 8'h00);
      no_reset(2, 10);
      rd("bod disabled", RSCC_CAUSE_ADDR, 8'h00);
      no_reset(3, 1);
      @(posedge mclk);
      wdog_en <= 1'b1;
      src_reset(3, 1, 8'h21);
      src_reset(4, 1, 8'h31);
      src_reset(2, 10, 8'h39);
      por_restart();
      close_out();
   end
endmodule
